// ==== acs_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer #(
  parameter int AXI_AW = 8
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [AXI_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [AXI_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Mode and strobe pins
  input  wire logic              mode_select_upper,
  input  wire logic              mode_select_lower,
  input  wire logic              wr_n,
  input  wire logic              rd_n,
  input  wire logic              convert_start_n,
  input  wire logic              cs_n,
  input  wire logic              shutdown_n,
  // Configuration pins
  input  wire logic              differential_select,
  input  wire logic [2:0]        channel_address_in,
  input  wire logic              polarity_select,
  input  wire logic              gain_select,
  // Converter core result, same clock
  input  wire logic [11:0]       adc_result,
  // Status and data pins
  output logic                   busy_n,
  output logic      [11:0]       data_out,
  output logic      [11:0]       data_oe_n,
  output logic                   differential_echo_out,
  output logic      [2:0]        address_echo_out,
  output logic                   echo_oe_n,
  // Multiplexer selection for the analog core
  output logic      [5:0]        mux_config
);
  localparam int PW = acs_pkg::PTR_W;
  localparam int CW = acs_pkg::CFG_W;

  generate
    if (AXI_AW < 4) begin : g_chk
      $error("acs_sequencer: address too narrow for register map");
    end
  endgenerate

  // Synchronised pins
  logic [acs_pkg::PIN_W-1:0] pins_s;
  acs_sync #(.W(acs_pkg::PIN_W), .RST(acs_pkg::PIN_RST)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({mode_select_upper, mode_select_lower, wr_n, rd_n, convert_start_n,
               cs_n, shutdown_n, differential_select, channel_address_in,
               polarity_select, gain_select}),
    .q       (pins_s)
  );

  // State registers
  logic [1:0]                mode_bits_r;   // Mode pins seen last cycle
  logic                      wr_prev_r;     // Strobe history for edges
  logic                      rd_prev_r;
  logic                      cv_prev_r;
  logic [PW-1:0]             ptr_r;         // Entry pointer
  logic [PW-1:0]             last_r;        // Index of final entry
  logic [2:0]                scan_r;        // Scan address counter
  logic [CW-1:0]             cfg_hold_r;    // Pins held after write rise
  logic                      rb_active_r;   // Readback word on the pins
  logic [acs_pkg::WORD_W-1:0] rb_word_r;    // Word being read back
  acs_pkg::acs_conv_t        conv_st_r;     // Converter state
  logic [acs_pkg::CONV_W-1:0] conv_cnt_r;   // Cycles left in conversion
  logic [acs_pkg::CONV_W-1:0] conv_cycles_r; // Software conversion length
  logic [CW-1:0]             conv_sel_r;    // Selection being converted
  logic [acs_pkg::RES_W-1:0] result_r;      // Last result
  logic [3:0]                echo_r;        // Selection of last result

  // Decoded pins
  wire [1:0]    mode_s   = {pins_s[acs_pkg::PIN_UPPER], pins_s[acs_pkg::PIN_LOWER]};
  wire          wr_s     = pins_s[acs_pkg::PIN_WR];
  wire          rd_s     = pins_s[acs_pkg::PIN_RD];
  wire          cv_s     = pins_s[acs_pkg::PIN_CONV];
  wire          cs_s     = pins_s[acs_pkg::PIN_CS];
  wire          shutdown_n_s   = pins_s[acs_pkg::PIN_SHUTDOWN_N];
  wire [CW-1:0] cfg_pins = pins_s[CW-1:0];

  // Mode decode from the held mode pins
  acs_pkg::acs_mode_t mode;
  assign mode = mode_bits_r[1] ?
                (mode_bits_r[0] ? acs_pkg::MODE_RUN  : acs_pkg::MODE_PROG) :
                (mode_bits_r[0] ? acs_pkg::MODE_SCAN : acs_pkg::MODE_DIRECT);
  wire in_prog = (mode == acs_pkg::MODE_PROG);
  wire in_run  = (mode == acs_pkg::MODE_RUN);
  wire in_scan = (mode == acs_pkg::MODE_SCAN);

  // Edge and event detection
  wire mode_chg  = (mode_s != mode_bits_r);
  wire lower_chg = (mode_s[0] != mode_bits_r[0]);
  wire wr_rise   = wr_s & ~wr_prev_r;
  wire rd_fall   = ~rd_s & rd_prev_r;
  wire rd_rise   = rd_s & ~rd_prev_r;
  wire cv_fall   = ~cv_s & cv_prev_r;
  wire wr_ev     = in_prog & wr_rise & rd_s & ~mode_chg;
  wire rb_fall   = in_prog & rd_fall & wr_s & ~mode_chg;
  wire rb_rise   = in_prog & rd_rise & rb_active_r & ~mode_chg;
  wire conv_idle = (conv_st_r == acs_pkg::CONV_IDLE);
  // Start needs select, no shutdown, idle core, not programming
  wire conv_start = cv_fall & ~cs_s & shutdown_n_s & ~in_prog & conv_idle & ~mode_chg;
  wire conv_done  = ~conv_idle & (conv_cnt_r <= acs_pkg::CONV_W'(1));
  wire run_adv    = conv_done & in_run & ~mode_chg;
  wire eos_hit    = (ptr_r == last_r);

  // Pointer: mode change wins over every advance
  wire [PW-1:0] ptr_inc = PW'(ptr_r + 1'h1);
  wire [PW-1:0] ptr_nxt = mode_chg           ? '0 :
                          (wr_ev | rb_rise)  ? ptr_inc :
                          run_adv            ? (eos_hit ? '0 : ptr_inc) :
                          ptr_r;
  wire [PW-1:0] last_nxt = wr_ev ? ptr_r : last_r;

  // Configuration pins transparent while write is low
  wire [CW-1:0] live_cfg = wr_s ? cfg_hold_r : cfg_pins;
  wire [CW-1:0] scan_sel = {live_cfg[acs_pkg::C_DIFFERENTIAL_SELECT], scan_r, live_cfg[acs_pkg::C_LOW:0]};

  // Sequence memory, read address follows the next pointer
  logic [acs_pkg::WORD_W-1:0] mem_rdata;
  acs_seq_mem #(.DEPTH(acs_pkg::ENTRIES), .W(acs_pkg::WORD_W)) u_mem (
    .aclk  (aclk),
    .we    (wr_ev),
    .waddr (ptr_r),
    .wdata ({cfg_hold_r, 1'h1}),
    .raddr (ptr_nxt),
    .rdata (mem_rdata)
  );
  wire [CW-1:0] mem_cfg = mem_rdata[acs_pkg::WORD_W-1:1];

  // Selection taken at convert start, per mode
  wire [CW-1:0] start_sel = in_run  ? mem_cfg :
                            in_scan ? scan_sel : live_cfg;
  wire [2:0] scan_step = conv_sel_r[acs_pkg::C_DIFFERENTIAL_SELECT] ? 3'h2 : 3'h1;
  wire [2:0] scan_nxt  = lower_chg ? 3'h0 :
                         (conv_done & in_scan) ? 3'(scan_r + scan_step) : scan_r;

  // Readback tracking
  wire rb_nxt = mode_chg ? 1'h0 : rb_fall ? 1'h1 : rb_rise ? 1'h0 : rb_active_r;
  wire [acs_pkg::WORD_W-1:0] rb_word_nxt = rb_fall ? {mem_cfg, eos_hit} : rb_word_r;

  // Converter state machine
  acs_pkg::acs_conv_t          conv_st_nxt;
  logic [acs_pkg::CONV_W-1:0]  conv_cnt_nxt;
  always_comb begin
    conv_st_nxt  = conv_st_r;
    conv_cnt_nxt = conv_cnt_r;
    unique case (conv_st_r)
      acs_pkg::CONV_IDLE: begin
        if (conv_start) begin
          conv_st_nxt  = acs_pkg::CONV_BUSY;
          conv_cnt_nxt = conv_cycles_r;
        end
      end
      acs_pkg::CONV_BUSY: begin
        if (conv_done) begin
          conv_st_nxt = acs_pkg::CONV_IDLE;
        end else begin
          conv_cnt_nxt = conv_cnt_r - 1'h1;
        end
      end
    endcase
  end

  // Pin outputs: readback word or conversion result
  wire norm_oe = ~cs_s & ~rd_s & ~in_prog;
  wire [11:0] data_nxt = rb_active_r ? {rb_word_r[2:0], 9'h000} : result_r;
  wire [11:0] oe_nxt   = rb_active_r ? {3'h0, 9'h1ff} :
                         norm_oe     ? 12'h000 : 12'hfff;
  wire [3:0]  echo_out_nxt = rb_active_r ? rb_word_r[6:3] : echo_r;
  wire        busy_n_nxt   = ~in_prog & conv_idle;

  // Sequencer and converter registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_bits_r <= 2'h0;
      wr_prev_r   <= 1'h1;
      rd_prev_r   <= 1'h1;
      cv_prev_r   <= 1'h1;
      ptr_r       <= '0;
      last_r      <= '0;
      scan_r      <= 3'h0;
      cfg_hold_r  <= '0;
      rb_active_r <= 1'h0;
      rb_word_r   <= '0;
      conv_st_r   <= acs_pkg::CONV_IDLE;
      conv_cnt_r  <= '0;
      conv_sel_r  <= '0;
      result_r    <= '0;
      echo_r      <= 4'h0;
    end else begin
      mode_bits_r <= mode_s;
      wr_prev_r   <= wr_s;
      rd_prev_r   <= rd_s;
      cv_prev_r   <= cv_s;
      ptr_r       <= ptr_nxt;
      last_r      <= last_nxt;
      scan_r      <= scan_nxt;
      cfg_hold_r  <= live_cfg;
      rb_active_r <= rb_nxt;
      rb_word_r   <= rb_word_nxt;
      conv_st_r   <= conv_st_nxt;
      conv_cnt_r  <= conv_cnt_nxt;
      conv_sel_r  <= conv_start ? start_sel : conv_sel_r;
      result_r    <= conv_done ? adc_result : result_r;
      echo_r      <= conv_done ? conv_sel_r[CW-1:acs_pkg::C_LOW+1] : echo_r;
    end
  end

  // Registered pin outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_n     <= 1'h1;
      data_out   <= 12'h000;
      data_oe_n  <= 12'hfff;
      {differential_echo_out, address_echo_out} <= 4'h0;
      echo_oe_n  <= 1'h1;
      mux_config <= '0;
    end else begin
      busy_n     <= busy_n_nxt;
      data_out   <= data_nxt;
      data_oe_n  <= oe_nxt;
      {differential_echo_out, address_echo_out} <= echo_out_nxt;
      echo_oe_n  <= ~(rb_active_r | norm_oe);
      mux_config <= conv_sel_r;
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  logic                 aw_have_r;
  logic                 w_have_r;
  logic [AXI_AW-1:0]    aw_addr_r;
  logic [31:0]          w_data_r;
  logic                 w_strb0_r;
  wire aw_hs  = awvalid & awready;
  wire w_hs   = wvalid & wready;
  wire commit = aw_have_r & w_have_r & ~bvalid;
  wire aw_nxt = aw_hs | (aw_have_r & ~commit);
  wire w_nxt  = w_hs | (w_have_r & ~commit);
  wire bv_nxt = commit | (bvalid & ~bready);
  wire wa_ctrl = (aw_addr_r == AXI_AW'(acs_pkg::ADDR_CTRL));
  wire wa_ok   = wa_ctrl | (aw_addr_r == AXI_AW'(acs_pkg::ADDR_STATUS)) |
                 (aw_addr_r == AXI_AW'(acs_pkg::ADDR_RESULT));

  // AXI4-Lite read path: answer one cycle after the address
  wire ar_hs  = arvalid & arready;
  wire rv_nxt = ar_hs | (rvalid & ~rready);
  wire ra_ctrl   = (araddr == AXI_AW'(acs_pkg::ADDR_CTRL));
  wire ra_status = (araddr == AXI_AW'(acs_pkg::ADDR_STATUS));
  wire ra_result = (araddr == AXI_AW'(acs_pkg::ADDR_RESULT));
  // Status: converting, busy, mode pins, final index, pointer
  wire [31:0] status_word = {20'h0_0000, ~conv_idle, ~busy_n, mode_bits_r, last_r, ptr_r};
  wire [31:0] rd_word = ra_ctrl   ? {24'h00_0000, conv_cycles_r} :
                        ra_status ? status_word :
                        ra_result ? {16'h0000, echo_r, result_r} : 32'h0000_0000;
  wire [1:0]  rd_resp = (ra_ctrl | ra_status | ra_result) ?
                        acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;

  // Bus slave registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'h0;
      w_have_r      <= 1'h0;
      aw_addr_r     <= '0;
      w_data_r      <= 32'h0000_0000;
      w_strb0_r     <= 1'h0;
      awready       <= 1'h0;
      wready        <= 1'h0;
      bvalid        <= 1'h0;
      bresp         <= acs_pkg::RESP_OKAY;
      arready       <= 1'h0;
      rvalid        <= 1'h0;
      rdata         <= 32'h0000_0000;
      rresp         <= acs_pkg::RESP_OKAY;
      conv_cycles_r <= acs_pkg::CONV_RST;
    end else begin
      aw_have_r <= aw_nxt;
      w_have_r  <= w_nxt;
      aw_addr_r <= aw_hs ? awaddr : aw_addr_r;
      w_data_r  <= w_hs ? wdata : w_data_r;
      w_strb0_r <= w_hs ? wstrb[0] : w_strb0_r;
      awready   <= ~aw_nxt & ~bv_nxt;
      wready    <= ~w_nxt & ~bv_nxt;
      bvalid    <= bv_nxt;
      bresp     <= commit ? (wa_ok ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR) : bresp;
      arready   <= ~rv_nxt;
      rvalid    <= rv_nxt;
      rdata     <= ar_hs ? rd_word : rdata;
      rresp     <= ar_hs ? rd_resp : rresp;
      if (commit & wa_ctrl & w_strb0_r) begin
        conv_cycles_r <= w_data_r[acs_pkg::CONV_W-1:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_prog_busy_low: assert property (in_prog |=> !busy_n)
    else $error("busy high in program mode");
  a_busy_return: assert property (!in_prog && conv_idle |=> busy_n)
    else $error("busy not restored after program mode");
  a_mode_ptr_zero: assert property (mode_chg |=> ptr_r == '0)
    else $error("pointer not reset on mode change");
  a_write_advance: assert property (wr_ev |=> ptr_r == PW'($past(ptr_r) + 1'h1)
                                     && last_r == $past(ptr_r))
    else $error("write did not advance pointer or final index");
  a_rb_low_hiz: assert property (rb_active_r |=> &data_oe_n[8:0] && !echo_oe_n)
    else $error("lower data pins driven in readback");
  a_rb_eos_flag: assert property (rb_fall |=> rb_word_r[0] == $past(eos_hit))
    else $error("end flag wrong in readback");
  a_rb_release: assert property (rb_rise |-> ##2 (&data_oe_n))
    else $error("data pins not released on read rise");
  a_run_wrap: assert property (run_adv && eos_hit |=> ptr_r == '0)
    else $error("pointer did not wrap after final entry");
  a_echo_sel: assert property (conv_done ##1 1'h1 |=> {differential_echo_out,
                               address_echo_out} == $past(conv_sel_r[5:2], 2)
                               || rb_active_r)
    else $error("echo does not show converted selection");
  a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

  c_prog_write: cover property (wr_ev ##[1:50] wr_ev);
  c_readback: cover property (rb_fall ##[1:50] rb_rise);
  c_run_wrap: cover property (run_adv && eos_hit);
  c_scan_conv: cover property (conv_done && in_scan);
endmodule // acs_sequencer
`default_nettype wire

// ==== acs_pkg.sv ====
`default_nettype none
package acs_pkg;
  // Sequence memory geometry
  localparam int ENTRIES = 16;
  localparam int PTR_W   = 4;
  localparam int WORD_W  = 7;
  localparam int CFG_W   = 6;
  localparam int RES_W   = 12;
  localparam int RB_HI_W = 3;
  localparam int RB_LO_W = 9;

  // Synchronised pin vector layout
  localparam int PIN_W     = 13;
  localparam int PIN_UPPER = 12;
  localparam int PIN_LOWER = 11;
  localparam int PIN_WR    = 10;
  localparam int PIN_RD    = 9;
  localparam int PIN_CONV  = 8;
  localparam int PIN_CS    = 7;
  localparam int PIN_SHUTDOWN_N  = 6;
  // Strobes idle high, modes and config low
  localparam logic [PIN_W-1:0] PIN_RST = 13'h07c0;

  // Configuration field layout: differential_select, addr[2:0], polarity, gain
  localparam int C_DIFFERENTIAL_SELECT = 5;
  localparam int C_ADDR = 2;
  localparam int C_LOW  = 1;

  // Register map, byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Conversion length in clock cycles
  localparam int         CONV_W   = 8;
  localparam logic [7:0] CONV_RST = 8'h10;

  // Operating modes and converter states
  typedef enum logic [1:0] {MODE_DIRECT, MODE_SCAN, MODE_PROG, MODE_RUN} acs_mode_t;
  typedef enum logic {CONV_IDLE, CONV_BUSY} acs_conv_t;
endpackage
`default_nettype wire

// ==== acs_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Raw and synchronised levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;  // First stage, read only by second

  generate
    if (W < 1) begin : g_chk
      $error("acs_sync: width must be positive");
    end
  endgenerate

  // Two-stage level synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= RST;
      q    <= RST;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule // acs_sync
`default_nettype wire

// ==== acs_seq_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_seq_mem #(
  parameter int DEPTH = 16,
  parameter int W     = 7,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic          aclk,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  // Registered read port
  input  wire logic [AW-1:0] raddr,
  output logic      [W-1:0]  rdata
);
  logic [W-1:0] mem [DEPTH];  // Entry storage, no reset: keeps sequence

  generate
    if (DEPTH != (1 << AW) || W < 1) begin : g_chk
      $error("acs_seq_mem: depth must be a power of two");
    end
  endgenerate

  // Write, and read into a register
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // acs_seq_mem
`default_nettype wire

// ==== acs_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_host (
  // Clock
  input  wire logic       aclk,
  // Mode and strobe pins
  output logic            mode_select_upper,
  output logic            mode_select_lower,
  output logic            wr_n,
  output logic            rd_n,
  output logic            convert_start_n,
  output logic            cs_n,
  output logic            shutdown_n,
  // Configuration pins {differential_select, addr, polarity, gain}
  output logic      [5:0] cfg
);
  // Idle levels from time zero, strobes high except cs_n, held low
  initial begin
    {mode_select_upper, mode_select_lower} = 2'b00;
    {wr_n, rd_n, convert_start_n, shutdown_n} = 4'hf;
    cs_n = 1'b0;
    cfg = 6'h00;
  end
  // Let clock edges pass
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Move both mode pins, then let synchronisers settle
  task automatic set_mode(input logic u, input logic l);
    mode_select_upper <= u;
    mode_select_lower <= l;
    idle(6);
  endtask
  // Write pulse with read high; pins scrambled once released
  task automatic strobe_wr(input logic [5:0] c);
    rd_n <= 1'b1;
    cfg <= c;
    wr_n <= 1'b0;
    idle(4);
    wr_n <= 1'b1;
    idle(1);
    cfg <= ~c;
    idle(5);
  endtask
  // Read pulse with write held high
  task automatic strobe_rd();
    wr_n <= 1'b1;
    rd_n <= 1'b0;
    idle(4);
    rd_n <= 1'b1;
    idle(6);
  endtask
  // Convert start pulse of two cycles
  task automatic convert();
    convert_start_n <= 1'b0;
    idle(2);
    convert_start_n <= 1'b1;
    idle(1);
  endtask
endmodule // acs_host
`default_nettype wire

// ==== acs_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb_top;
  // Clock, reset, converter result and AXI master side
  logic        aclk, aresetn;
  logic [11:0] adc_result;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  // Pins
  logic        mode_select_upper, mode_select_lower, wr_n, rd_n, convert_start_n;
  logic        cs_n, shutdown_n, busy_n, differential_echo_out, echo_oe_n;
  logic [5:0]  cfg, mux_config, c;
  logic [11:0] data_out, data_oe_n;
  logic [2:0]  address_echo_out;
  // Checking state
  logic [33:0] exp_q[$];
  logic [5:0]  mem[16];
  logic [15:0] rnd;
  logic        conv_wait, busy_q, eoe_q;
  int          num_errors, tests_run, cycles;

  // Free running clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  acs_host acs_host_inst (.aclk, .mode_select_upper, .mode_select_lower, .wr_n, .rd_n,
    .convert_start_n, .cs_n, .shutdown_n, .cfg);
  acs_sequencer acs_sequencer_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .mode_select_upper, .mode_select_lower, .wr_n, .rd_n,
    .convert_start_n, .cs_n, .shutdown_n, .differential_select(cfg[5]),
    .channel_address_in(cfg[4:2]), .polarity_select(cfg[1]), .gain_select(cfg[0]),
    .adc_result, .busy_n, .data_out, .data_oe_n, .differential_echo_out, .address_echo_out,
    .echo_oe_n, .mux_config);

  // Pseudo random sequence
  function automatic logic [15:0] nx(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction
  // Single comparison point
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Match an observed result with the oldest note
  task automatic take(input logic [33:0] v);
    if (exp_q.size() == 0) begin
      num_errors++;
      $display("unexpected at %0t: result with no note", $time);
    end else check(v, exp_q.pop_front());
  endtask
  // Result watcher
  always @(posedge aclk) begin
    if (bvalid && bready) take({bresp, 32'h0000_0000});
    if (rvalid && rready) take({rresp, rdata});
    if (conv_wait && busy_n && !busy_q) begin
      take({24'h00_0000, differential_echo_out, address_echo_out, mux_config});
      conv_wait = 1'b0;
    end
    if (eoe_q && !echo_oe_n) take({6'h00, data_oe_n, data_out & ~data_oe_n,
      differential_echo_out, address_echo_out});
    busy_q = busy_n;
    eoe_q = echo_oe_n;
  end
  // Hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end

  // AXI write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0000_0000});
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask
  // AXI read with expected response and data
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask
  // One conversion and its result register
  task automatic conv(input logic [5:0] sel);
    logic [11:0] res;
    rnd = nx(rnd);
    res = rnd[11:0];
    adc_result <= res;
    exp_q.push_back({24'h00_0000, sel[5:2], sel});
    conv_wait = 1'b1;
    acs_host_inst.convert();
    while (conv_wait) @(posedge aclk);
    exp_q.push_back({6'h00, 12'h000, res, sel[5:2]});
    acs_host_inst.strobe_rd();
    axi_rd(acs_pkg::ADDR_RESULT, {2'b00, 16'h0000, sel[5:2], res});
  endtask

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, conv_wait} = 7'h00;
    {awaddr, araddr, adc_result} = 28'h000_0000;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    rnd = 16'h6656;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(acs_pkg::ADDR_CTRL, 34'h0_0000_0010);
    axi_wr(acs_pkg::ADDR_CTRL, 32'h0000_0004, acs_pkg::RESP_OKAY);
    axi_rd(acs_pkg::ADDR_CTRL, 34'h0_0000_0004);
    axi_wr(8'h0c, 32'h0000_00ff, acs_pkg::RESP_SLVERR);
    axi_rd(8'h0c, {acs_pkg::RESP_SLVERR, 32'h0000_0000});
    $display("test registers done");
    acs_host_inst.set_mode(1'b1, 1'b0);
    check({33'h0_0000_0000, busy_n}, 34'h0_0000_0000);
    for (int i = 0; i < 18; i++) begin
      rnd = nx(rnd);
      mem[i % 16] = rnd[5:0];
      acs_host_inst.strobe_wr(rnd[5:0]);
    end
    axi_rd(acs_pkg::ADDR_STATUS, {22'h00_0000, 4'h6, 4'h1, 4'h2});
    acs_host_inst.set_mode(1'b1, 1'b1);
    acs_host_inst.set_mode(1'b1, 1'b0);
    axi_rd(acs_pkg::ADDR_STATUS, {22'h00_0000, 4'h6, 4'h1, 4'h0});
    for (int i = 0; i < 17; i++) begin
      exp_q.push_back({6'h00, 12'h1ff, mem[i % 16][1:0], (i % 16) == 1, 9'h000,
        mem[i % 16][5:2]});
      acs_host_inst.strobe_rd();
      check({21'h00_0000, echo_oe_n, data_oe_n}, {21'h00_0000, 13'h1fff});
    end
    $display("test program and readback done");
    acs_host_inst.set_mode(1'b1, 1'b1);
    check({33'h0_0000_0000, busy_n}, 34'h0_0000_0001);
    conv(mem[0]);
    conv(mem[1]);
    conv(mem[0]);
    acs_host_inst.cs_n <= 1'b1;
    acs_host_inst.shutdown_n <= 1'b0;
    acs_host_inst.convert();
    acs_host_inst.idle(2);
    check({33'h0_0000_0000, busy_n}, 34'h0_0000_0001);
    acs_host_inst.cs_n <= 1'b0;
    acs_host_inst.shutdown_n <= 1'b1;
    acs_host_inst.idle(10);
    conv(mem[1]);
    $display("test run done");
    acs_host_inst.set_mode(1'b0, 1'b0);
    rnd = nx(rnd);
    c = rnd[5:0];
    acs_host_inst.strobe_wr(c);
    conv(c);
    acs_host_inst.set_mode(1'b0, 1'b1);
    c = {1'b0, rnd[9:5]};
    acs_host_inst.strobe_wr(c);
    conv({4'h0, c[1:0]});
    conv({4'h1, c[1:0]});
    acs_host_inst.strobe_wr({1'b1, c[4:0]});
    conv({4'ha, c[1:0]});
    conv({4'hc, c[1:0]});
    $display("test direct and scan done");
    acs_host_inst.set_mode(1'b1, 1'b1);
    conv(mem[0]);
    $display("test return to run done");
    finish_test();
  end
endmodule // acs_sequencer_tb_top
`default_nettype wire
